// file: mfi_decode_pkg.sv
// Package: function codes, carriers and sizes for the input terminal decoder
package mfi_decode_pkg;

	localparam int TERMINAL_COUNT = 5;
	localparam int CODE_W         = 6;
	localparam int PULSE_TERMINAL = 4;

	localparam logic [5:0] CODE_LENGTH_RESET  = 6'h1C;
	localparam logic [5:0] CODE_PULSE_INPUT   = 6'h1E;
	localparam logic [5:0] CODE_DC_BRAKE_NOW  = 6'h20;
	localparam logic [5:0] CODE_EXT_FAULT_NC  = 6'h21;
	localparam logic [5:0] CODE_PID_REVERSE   = 6'h23;
	localparam logic [5:0] CODE_KEY_STOP      = 6'h24;
	localparam logic [5:0] CODE_CMD_TOGGLE    = 6'h25;
	localparam logic [5:0] CODE_PID_INT_HOLD  = 6'h26;
	localparam logic [5:0] CODE_SRC_X_KEY     = 6'h27;
	localparam logic [5:0] CODE_SRC_Y_KEY     = 6'h28;
	localparam logic [5:0] CODE_PID_GAIN_SEL  = 6'h2B;
	localparam logic [5:0] CODE_EMERG_STOP    = 6'h2F;
	localparam logic [5:0] CODE_STOP_DECEL4   = 6'h30;
	localparam logic [5:0] CODE_DECEL_DC      = 6'h31;
	localparam logic [5:0] CODE_CLEAR_RUNTIME = 6'h32;

	localparam logic [1:0] CMD_SRC_KEYPAD = 2'h0;
	localparam logic [1:0] CMD_SRC_TERM   = 2'h1;
	localparam logic [1:0] CMD_SRC_COMM   = 2'h2;

	localparam logic [1:0] DECEL_TIME_4   = 2'h3;
	localparam logic [1:0] CMD_SRC_RESET  = 2'h1;

	// Stop style handed to the drive core
	typedef enum logic [2:0] {
		STOP_NONE,
		STOP_KEYPAD,
		STOP_DECEL4,
		STOP_EMERGENCY,
		STOP_DECEL_DC,
		STOP_DC_NOW,
		STOP_FAULT
	} stop_kind_t;

	// Decoded actions for the drive core
	typedef struct packed {
		logic       pulse_input_en;
		logic       dc_brake_now;
		logic       ext_fault;
		logic       pid_reverse;
		logic       pid_int_hold;
		logic       src_x_keypad;
		logic       src_y_keypad;
		logic       pid_gain_set2;
		logic       emergency_stop;
		logic       current_at_limit;
		logic       decel_dc_brake;
		logic [1:0] decel_time_sel;
		logic       stop_request;
		stop_kind_t stop_kind;
		logic [1:0] cmd_source;
	} actions_t;

	// One-cycle events
	typedef struct packed {
		logic length_clear;
		logic runtime_clear;
		logic cmd_toggled;
	} events_t;

endpackage

// file: mfi_decode.sv
// Multi-function input terminal decoder, function codes 28 to 50
//
// Summary of operation
// R1 - Five input terminals, each with its own configurable function code.
// R2 - Code 30 makes terminal five a pulse input; ignored on other terminals.
// R3 - Code 32 active enters DC braking at once, no deceleration.
// R4 - Code 33 signalling valid raises external fault and stops the drive.
// R5 - Code 35 active inverts the configured PID action direction.
// R6 - Code 36 stops drive like panel stop key, only under keypad control.
// R7 - Code 37 toggles command source between terminal and communication control.
// R8 - Code 38 active freezes the PID integral, other terms keep working.
// R9 - Code 39 active replaces frequency source X with keypad frequency.
// R10 - Code 40 active replaces frequency source Y with keypad frequency.
// R11 - Code 43 picks PID gain set two when active, if terminal-selected.
// R12 - Code 47 stops as fast as possible with current at upper limit.
// R13 - Code 48 decelerates to stop using deceleration time four, any source.
// R14 - Code 49 decelerates to DC brake start frequency, then DC brakes.
// R15 - Code 50 clears elapsed time of the current run.
// R16 - Reserved codes do nothing; length-reset code clears the length counter.
// R17 - Outside equipment holds each terminal level for at least one clock edge.
`timescale 1ns/10ps

module mfi_decode
	import mfi_decode_pkg::*;
#(
	parameter int N_TERM = TERMINAL_COUNT
) (
	input  wire logic                      ref_clk,
	input  wire logic                      rst,
	input  wire logic [N_TERM-1:0]         multi_function_input,
	input  wire logic [N_TERM*CODE_W-1:0]  term_code,
	input  wire logic [1:0]                cmd_source_cfg,
	input  wire logic                      pid_reverse_cfg,
	input  wire logic                      gain_switch_by_terminal,
	output actions_t                       actions,
	output events_t                        events,
	output logic                           pid_direction
);

	// Decode helper: any active terminal carrying the given code
	function automatic logic any_active(input logic [N_TERM-1:0] lvl,
		input logic [N_TERM*CODE_W-1:0] codes, input logic [CODE_W-1:0] code);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < N_TERM; i++) begin
			if (lvl[i] && codes[i*CODE_W +: CODE_W] == code) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

	// Helper: any terminal carrying the code, whatever its level
	function automatic logic any_assigned(input logic [N_TERM*CODE_W-1:0] codes,
		input logic [CODE_W-1:0] code);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < N_TERM; i++) begin
			if (codes[i*CODE_W +: CODE_W] == code) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

	logic [N_TERM-1:0] level_ff;
	logic [N_TERM-1:0] level_prev_ff;
	logic [N_TERM-1:0] rise_lvl;
	logic [N_TERM-1:0] fault_lvl;
	logic              act_dc_now;
	logic              act_fault;
	logic              act_keystop;
	logic              act_stop4;
	logic              act_emerg;
	logic              act_decel_dc;
	logic              toggle_rise;
	logic              nxt_toggle_seen;
	logic              toggle_seen_ff;
	logic [1:0]        cmd_source_ff;
	logic              length_rise;
	logic              runtime_rise;
	actions_t          nxt_actions;

	// Register terminal levels once; one edge of stable level is enough
	// R17 - single sample capture
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			level_ff      <= '0;
			level_prev_ff <= '0;
		end else begin
			level_ff      <= multi_function_input;
			level_prev_ff <= level_ff;
		end
	end

	// Normally closed fault contact is valid when the contact opens
	always_comb begin
		for (int i = 0; i < N_TERM; i++) begin
			fault_lvl[i] = ~level_ff[i];
		end
	end

	// R1 - per-terminal code lookup
	assign act_dc_now   = any_active(level_ff, term_code, CODE_DC_BRAKE_NOW);
	// R4 - normally closed fault
	assign act_fault    = any_active(fault_lvl, term_code, CODE_EXT_FAULT_NC);
	// R6 - keypad-only stop
	assign act_keystop  = any_active(level_ff, term_code, CODE_KEY_STOP) && cmd_source_ff == CMD_SRC_KEYPAD;
	// R13 - stop in any source
	assign act_stop4    = any_active(level_ff, term_code, CODE_STOP_DECEL4);
	// R12 - emergency stop
	assign act_emerg    = any_active(level_ff, term_code, CODE_EMERG_STOP);
	// R14 - decelerate then brake
	assign act_decel_dc = any_active(level_ff, term_code, CODE_DECEL_DC);

	// Edge events, taken from the registered copy only
	assign rise_lvl     = level_ff & ~level_prev_ff;
	// R7 - rising edge toggles source
	assign toggle_rise  = any_active(rise_lvl, term_code, CODE_CMD_TOGGLE);
	// R16 - length counter clear
	assign length_rise  = any_active(rise_lvl, term_code, CODE_LENGTH_RESET);
	// R15 - runtime clear
	assign runtime_rise = any_active(rise_lvl, term_code, CODE_CLEAR_RUNTIME);
	// No toggle event while keypad control pins the source
	assign nxt_toggle_seen = toggle_rise && cmd_source_cfg != CMD_SRC_KEYPAD;

	// Command source follows a keypad configuration and reloads it on leaving keypad unless a toggle then selects comm; a toggle flips terminal and comm
	// R7 - command source toggle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cmd_source_ff  <= CMD_SRC_RESET;
			toggle_seen_ff <= 1'b0;
		end else begin
			toggle_seen_ff <= nxt_toggle_seen;
			if (cmd_source_cfg == CMD_SRC_KEYPAD) begin
				cmd_source_ff <= CMD_SRC_KEYPAD;
			end else if (toggle_rise) begin
				cmd_source_ff <= (cmd_source_ff == CMD_SRC_COMM) ? CMD_SRC_TERM : CMD_SRC_COMM;
			end else if (cmd_source_ff == CMD_SRC_KEYPAD) begin
				cmd_source_ff <= cmd_source_cfg;
			end
		end
	end

	// Combine actions; stop priority puts fault and braking ahead of soft stops
	always_comb begin
		nxt_actions = '0;
		// R2 - pulse input only on terminal five
		nxt_actions.pulse_input_en = term_code[PULSE_TERMINAL*CODE_W +: CODE_W] == CODE_PULSE_INPUT;
		// R3 - immediate DC braking
		nxt_actions.dc_brake_now   = act_dc_now;
		nxt_actions.ext_fault      = act_fault;
		// R5 - PID direction inversion
		nxt_actions.pid_reverse    = any_active(level_ff, term_code, CODE_PID_REVERSE);
		// R8 - integral hold
		nxt_actions.pid_int_hold   = any_active(level_ff, term_code, CODE_PID_INT_HOLD);
		// R9 - source X to keypad
		nxt_actions.src_x_keypad   = any_active(level_ff, term_code, CODE_SRC_X_KEY);
		// R10 - source Y to keypad
		nxt_actions.src_y_keypad   = any_active(level_ff, term_code, CODE_SRC_Y_KEY);
		// R11 - gain set select
		nxt_actions.pid_gain_set2  = gain_switch_by_terminal &&
			any_active(level_ff, term_code, CODE_PID_GAIN_SEL);
		// R12 - fastest stop with current limit
		nxt_actions.emergency_stop   = act_emerg;
		nxt_actions.current_at_limit = act_emerg;
		nxt_actions.decel_dc_brake   = act_decel_dc;
		nxt_actions.cmd_source       = cmd_source_ff;
		nxt_actions.stop_request     = act_fault | act_dc_now | act_emerg | act_decel_dc | act_stop4 | act_keystop;
		// R13 - decel time four
		if (act_stop4) begin
			nxt_actions.decel_time_sel = DECEL_TIME_4;
		end
		if (act_fault) begin
			nxt_actions.stop_kind = STOP_FAULT;
		end else if (act_dc_now) begin
			nxt_actions.stop_kind = STOP_DC_NOW;
		end else if (act_emerg) begin
			nxt_actions.stop_kind = STOP_EMERGENCY;
		end else if (act_decel_dc) begin
			nxt_actions.stop_kind = STOP_DECEL_DC;
		end else if (act_stop4) begin
			nxt_actions.stop_kind = STOP_DECEL4;
		end else if (act_keystop) begin
			nxt_actions.stop_kind = STOP_KEYPAD;
		end else begin
			nxt_actions.stop_kind = STOP_NONE;
		end
	end

	// Registered action outputs
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			actions       <= '0;
			pid_direction <= 1'b0;
		end else begin
			actions       <= nxt_actions;
			pid_direction <= pid_reverse_cfg ^ nxt_actions.pid_reverse;
		end
	end

	// Registered one-cycle events; reserved codes match nothing here
	// R16 - length clear event
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			events <= '0;
		end else begin
			events.length_clear  <= length_rise;
			events.runtime_clear <= runtime_rise;
			events.cmd_toggled   <= toggle_seen_ff;
		end
	end

	// Assertions
	sequence s_rise(int code);
		any_active(rise_lvl, term_code, code[CODE_W-1:0]);
	endsequence

	// Clear events last one cycle unless another terminal rises right behind
	sequence s_clear_pulse(ev, rise);
		ev ##1 (!ev || $past(rise));
	endsequence

	a_dc_brake_now: assert property (@(posedge ref_clk) disable iff (rst) // R3
		act_dc_now |=> actions.dc_brake_now && actions.stop_kind inside {STOP_DC_NOW, STOP_FAULT})
		else $error("dc brake not taken");
	a_fault_stop: assert property (@(posedge ref_clk) disable iff (rst) // R4
		act_fault |=> actions.ext_fault && actions.stop_request && actions.stop_kind == STOP_FAULT)
		else $error("external fault not raised");
	a_pid_dir_flip: assert property (@(posedge ref_clk) disable iff (rst) // R5
		##1 pid_direction == ($past(pid_reverse_cfg) ^ actions.pid_reverse))
		else $error("pid direction wrong");
	a_key_stop_mode: assert property (@(posedge ref_clk) disable iff (rst) // R6
		(actions.stop_kind == STOP_KEYPAD) |-> actions.cmd_source == CMD_SRC_KEYPAD)
		else $error("keypad stop outside keypad mode");
	a_toggle_source: assert property (@(posedge ref_clk) disable iff (rst) // R7
		(s_rise(CODE_CMD_TOGGLE) and cmd_source_cfg != CMD_SRC_KEYPAD) |=>
		cmd_source_ff != $past(cmd_source_ff) ##1 events.cmd_toggled)
		else $error("command source not toggled");
	a_gain_select: assert property (@(posedge ref_clk) disable iff (rst) // R11
		!gain_switch_by_terminal |=> !actions.pid_gain_set2)
		else $error("gain set switched without terminal selection");
	a_emerg_limit: assert property (@(posedge ref_clk) disable iff (rst) // R12
		act_emerg |=> actions.emergency_stop && actions.current_at_limit && actions.stop_request)
		else $error("emergency stop missing");
	a_stop_decel4: assert property (@(posedge ref_clk) disable iff (rst) // R13
		act_stop4 |=> actions.decel_time_sel == DECEL_TIME_4 && actions.stop_request)
		else $error("decel time four not used");
	a_runtime_clear: assert property (@(posedge ref_clk) disable iff (rst) // R15
		s_rise(CODE_CLEAR_RUNTIME) |=> s_clear_pulse(events.runtime_clear, runtime_rise))
		else $error("runtime clear not pulsed");
	a_length_clear: assert property (@(posedge ref_clk) disable iff (rst) // R16
		events.length_clear |-> $past(any_assigned(term_code, CODE_LENGTH_RESET)))
		else $error("length clear without assignment");

	// Level actions show one edge after the decoded terminal level
	a_pulse_term_five: assert property (@(posedge ref_clk) disable iff (rst) // R2
		term_code[PULSE_TERMINAL*CODE_W +: CODE_W] != CODE_PULSE_INPUT |=> !actions.pulse_input_en)
		else $error("pulse input enabled off terminal five");
	a_pid_reverse_on: assert property (@(posedge ref_clk) disable iff (rst) // R5
		any_active(level_ff, term_code, CODE_PID_REVERSE) |=> actions.pid_reverse)
		else $error("pid reverse not decoded");
	a_int_hold_on: assert property (@(posedge ref_clk) disable iff (rst) // R8
		any_active(level_ff, term_code, CODE_PID_INT_HOLD) |=> actions.pid_int_hold)
		else $error("integral hold not decoded");
	a_src_x_key: assert property (@(posedge ref_clk) disable iff (rst) // R9
		any_active(level_ff, term_code, CODE_SRC_X_KEY) |=> actions.src_x_keypad)
		else $error("source x not replaced");
	a_src_y_key: assert property (@(posedge ref_clk) disable iff (rst) // R10
		any_active(level_ff, term_code, CODE_SRC_Y_KEY) |=> actions.src_y_keypad)
		else $error("source y not replaced");
	a_gain_set_two: assert property (@(posedge ref_clk) disable iff (rst) // R11
		gain_switch_by_terminal && any_active(level_ff, term_code, CODE_PID_GAIN_SEL) |=> actions.pid_gain_set2)
		else $error("gain set two not selected");

	// Stop styles and their order of precedence
	// A stop with no cause would let reserved codes halt the drive
	a_dc_now_rank: assert property (@(posedge ref_clk) disable iff (rst) // R3
		act_dc_now && !act_fault |=> actions.stop_kind == STOP_DC_NOW)
		else $error("dc brake outranked");
	a_key_stop_taken: assert property (@(posedge ref_clk) disable iff (rst) // R6
		act_keystop |=> actions.stop_request)
		else $error("keypad stop not requested");
	a_decel4_rank: assert property (@(posedge ref_clk) disable iff (rst) // R13
		act_stop4 && !(act_fault || act_dc_now || act_emerg || act_decel_dc) |=> actions.stop_kind == STOP_DECEL4)
		else $error("decel four stop kind wrong");
	a_decel_dc_stop: assert property (@(posedge ref_clk) disable iff (rst) // R14
		act_decel_dc |=> actions.decel_dc_brake && actions.stop_request)
		else $error("decel dc brake missing");
	a_stop_needs_cause: assert property (@(posedge ref_clk) disable iff (rst) // R16
		!(act_fault || act_dc_now || act_emerg || act_decel_dc || act_stop4 || act_keystop) |=>
		!actions.stop_request && actions.stop_kind == STOP_NONE)
		else $error("stop without cause");

	// Source pinned by keypad; clear edges last one cycle
	// Keypad control must not be left by a stray toggle edge
	a_keypad_pins_source: assert property (@(posedge ref_clk) disable iff (rst) // R7
		cmd_source_cfg == CMD_SRC_KEYPAD |=> cmd_source_ff == CMD_SRC_KEYPAD)
		else $error("keypad source not held");
	a_length_pulse: assert property (@(posedge ref_clk) disable iff (rst) // R16
		s_rise(CODE_LENGTH_RESET) |=> s_clear_pulse(events.length_clear, length_rise))
		else $error("length clear not pulsed");

endmodule

// file: switch_bank.sv
// External contact bank that drives the five input terminals
`timescale 1ns/10ps

module switch_bank (
	input  wire logic       ref_clk,
	input  wire logic [4:0] want,
	output logic      [4:0] multi_function_input
);
	// contacts held stable
	// Contacts move only on falling edges, so each level spans a full rising edge
	initial multi_function_input = 5'h00;
	always @(negedge ref_clk) begin
		multi_function_input <= want;
	end
endmodule

// file: testbench.sv
// Self-checking bench for the input terminal decoder
`timescale 1ns/10ps
`define CHK(got, exp, msg) checks++; if ((got) !== (exp)) begin fails++; $display("MISMATCH %0t %s", $time, msg); end

module testbench;
	import mfi_decode_pkg::*;
	typedef struct packed {actions_t a; logic d;} note_t;
	logic        ref_clk   = 1'b0;
	logic        rst       = 1'b1;
	logic [4:0]  want      = 5'h00;
	logic [29:0] term_code = 30'h0;
	logic [1:0]  cfg       = CMD_SRC_TERM;
	logic        rev       = 1'b0;
	logic        gsel      = 1'b0;
	logic [4:0]  multi_function_input;
	actions_t    actions;
	events_t     events;
	logic        pid_direction;
	note_t       qa[$];
	events_t     qe[$];
	note_t       n;
	events_t     e;
	int          fails     = 0;
	int          checks    = 0;
	int          seed      = 32'hEA40788C;
	event        chk_ev;
	// Code 37 and the edge codes stay out, so random runs never toggle the source
	logic [5:0]  tbl[20]   = '{6'h1D, 6'h1E, 6'h1F, 6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h26, 6'h27,
		6'h28, 6'h29, 6'h2A, 6'h2B, 6'h2C, 6'h2F, 6'h30, 6'h31, 6'h00, 6'h3F};

	// 100 MHz clock
	always #5 ref_clk = ~ref_clk;

	switch_bank sw (.ref_clk(ref_clk), .want(want), .multi_function_input(multi_function_input));
	mfi_decode dut (.ref_clk(ref_clk), .rst(rst), .multi_function_input(multi_function_input),
		.term_code(term_code), .cmd_source_cfg(cfg), .pid_reverse_cfg(rev),
		.gain_switch_by_terminal(gsel), .actions(actions), .events(events), .pid_direction(pid_direction));

	// Reference decode of terminal levels and codes
	function automatic actions_t model(input logic [4:0] lv, input logic [29:0] cd, input logic [1:0] src,
		input logic g);
		actions_t   a;
		logic [5:0] c;
		logic       ks;
		a = '0;
		ks = 1'b0;
		for (int i = 0; i < 5; i++) begin
			c = cd[6*i +: 6];
			a.pulse_input_en |= (c == CODE_PULSE_INPUT) && (i == PULSE_TERMINAL);
			a.ext_fault |= (c == CODE_EXT_FAULT_NC) && !lv[i];
			if (lv[i]) begin
				a.dc_brake_now |= c == CODE_DC_BRAKE_NOW;
				a.pid_reverse |= c == CODE_PID_REVERSE;
				a.pid_int_hold |= c == CODE_PID_INT_HOLD;
				a.src_x_keypad |= c == CODE_SRC_X_KEY;
				a.src_y_keypad |= c == CODE_SRC_Y_KEY;
				a.pid_gain_set2 |= (c == CODE_PID_GAIN_SEL) && g;
				a.emergency_stop |= c == CODE_EMERG_STOP;
				a.decel_dc_brake |= c == CODE_DECEL_DC;
				ks |= (c == CODE_KEY_STOP) && (src == CMD_SRC_KEYPAD);
				if (c == CODE_STOP_DECEL4)
					a.decel_time_sel = DECEL_TIME_4;
			end
		end
		a.current_at_limit = a.emergency_stop;
		// Fault outranks every other stop style
		if (a.ext_fault) a.stop_kind = STOP_FAULT;
		else if (a.dc_brake_now) a.stop_kind = STOP_DC_NOW;
		else if (a.emergency_stop) a.stop_kind = STOP_EMERGENCY;
		else if (a.decel_dc_brake) a.stop_kind = STOP_DECEL_DC;
		else if (a.decel_time_sel == DECEL_TIME_4) a.stop_kind = STOP_DECEL4;
		else if (ks) a.stop_kind = STOP_KEYPAD;
		a.stop_request = a.stop_kind != STOP_NONE;
		a.cmd_source = src;
		return a;
	endfunction

	// Set contacts, let them settle past the two-edge latency, then note the expectation
	task automatic apply(input logic [4:0] lv, input logic [1:0] src);
		note_t t;
		want = lv;
		repeat (5) @(negedge ref_clk);
		t.a = model(lv, term_code, src, gsel);
		t.d = rev ^ t.a.pid_reverse;
		qa.push_back(t);
		-> chk_ev;
		@(negedge ref_clk);
	endtask

	task automatic test_done;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Level actions compared once the driver declares them settled
	always @(chk_ev) begin
		n = qa.pop_front();
		`CHK(actions, n.a, "decoded actions")
		`CHK(pid_direction, n.d, "pid direction")
	end

	// Any pulse takes the oldest noted event; an unexpected one compares against zero
	always @(negedge ref_clk) begin
		if (!rst && events !== 3'h0) begin
			e = (qe.size() > 0) ? qe.pop_front() : events_t'(3'h0);
			`CHK(events, e, "event pulse")
		end
	end

	// Hang guard
	initial begin
		#200000;
		fails++;
		$display("MISMATCH %0t timeout", $time);
		test_done;
	end

	initial begin
		repeat (10) @(negedge ref_clk);
		`CHK(actions, '0, "reset value")
		rst = 1'b0;
		// Source toggle terminal<->comm on rising edges
		term_code = {24'h0, CODE_CMD_TOGGLE};
		apply(5'h00, CMD_SRC_TERM);
		qe.push_back(events_t'(3'h1));
		apply(5'h01, CMD_SRC_COMM);
		apply(5'h00, CMD_SRC_COMM);
		qe.push_back(events_t'(3'h1));
		apply(5'h01, CMD_SRC_TERM);
		// Length and run-time clear, alone and together, held high without repeats
		term_code = {12'h0, CODE_CLEAR_RUNTIME, CODE_LENGTH_RESET, 6'h0};
		apply(5'h00, CMD_SRC_TERM);
		qe.push_back(events_t'(3'h4));
		apply(5'h02, CMD_SRC_TERM);
		qe.push_back(events_t'(3'h2));
		apply(5'h06, CMD_SRC_TERM);
		apply(5'h00, CMD_SRC_TERM);
		qe.push_back(events_t'(3'h6));
		apply(5'h06, CMD_SRC_TERM);
		apply(5'h00, CMD_SRC_TERM);
		// Random codes, levels, source and gain selection
		for (int k = 0; k < 300; k++) begin
			for (int i = 0; i < 5; i++)
				term_code[6*i +: 6] = tbl[$unsigned($random(seed)) % 20];
			{gsel, rev, cfg[0]} = 3'($random(seed));
			apply(5'($random(seed)), cfg);
		end
		// Late pulses get a bounded grace period
		for (int k = 0; k < 20 && qe.size() > 0; k++)
			@(negedge ref_clk);
		`CHK(qe.size(), 0, "missing event pulse")
		test_done;
	end
endmodule
